/* verilog/mem_dev_end.sv */
// Device end: write buffer, refill, reset sequencing, interrupts
`timescale 1ns/10ps
`include "mem_if_regs.svh"
module mem_dev_end #(
	parameter int unsigned COLD_CYCLES = `COLD_RESET_CYCLES
) (
	input  wire logic        clk_i,
	input  wire logic        nrst_i,
	mem_bus_if.dev           bus,
	input  wire logic        cold_reset_n_i,
	input  wire logic        warm_reset_n_i,
	input  wire logic [4:0]  user_irq_n_i,
	input  wire logic        float_unit_irq_n_i,
	input  wire logic        wr_valid_i,
	input  wire logic [31:0] wr_addr_i,
	input  wire logic [31:0] wr_data_i,
	input  wire logic [3:0]  wr_be_i,
	input  wire logic [2:0]  wr_type_i,
	input  wire logic        miss_i,
	input  wire logic        miss_icache_i,
	input  wire logic [31:0] miss_addr_i,
	output logic             wr_ready_o,
	output logic             stall_o,
	output logic             refill_valid_o,
	output logic      [31:0] refill_data_o,
	output logic      [2:0]  refill_index_o,
	output logic      [5:0]  cpu_irq_n_o,
	output logic             cpu_reset_n_o,
	output logic             cpu_reset_out_n_o,
	output logic             init_vector_valid_o,
	output logic      [3:0]  init_vector_o
);
	function automatic logic [3:0] byte_par(input logic [31:0] w);
		byte_par = {^w[31:24], ^w[23:16], ^w[15:8], ^w[7:0]};
	endfunction

	logic [31:0] wb_addr_reg [`WB_DEPTH];
	logic [31:0] wb_data_reg [`WB_DEPTH];
	logic [2:0]  wb_type_reg [`WB_DEPTH];
	logic [1:0]  head_reg;
	logic [1:0]  tail_reg;
	logic [2:0]  count_reg;
	logic [3:0]  hit;
	logic        merge;
	logic [1:0]  merge_idx;
	logic        push;
	logic        pop;
	logic [31:0] cmp_addr;
	logic [31:0] rd_addr_reg;
	logic [31:0] rd_data_reg;
	logic [3:0]  rd_par_reg;
	mem_if_pkg::rd_state_e  rd_state_reg;
	mem_if_pkg::rst_state_e rst_state_reg;
	logic [31:0] rst_cnt_reg;
	logic [4:0]  irq_meta_reg;
	logic [4:0]  irq_sync_reg;
	logic        block_reg;
	logic [2:0]  beat_reg;

	assign cmp_addr = miss_i ? miss_addr_i : wr_addr_i;
	always_comb begin
		merge     = 1'b0;
		merge_idx = 2'h0;
		for (int i = 0; i < `WB_DEPTH; i++) begin
			hit[i] = (3'(i) - {1'b0, head_reg}) % 3'h4 < count_reg
			         && wb_addr_reg[i][31:2] == cmp_addr[31:2];
			// merge only into entries not yet on the bus
			if (hit[i] && !(i == int'(head_reg) && !bus.write_buffer_out_en_n)) begin
				merge     = 1'b1;
				merge_idx = 2'(i);
			end
		end
	end

	// no new entry when full unless gathering
	assign wr_ready_o = (count_reg != 3'h4) || merge;
	assign push = wr_valid_i && !miss_i && !merge && count_reg != 3'h4;
	assign pop  = bus.write_done_ack && count_reg != 3'h0;

	always_ff @(posedge clk_i) begin
		if (wr_valid_i && !miss_i && merge) begin
			for (int b = 0; b < 4; b++)
				if (wr_be_i[b])
					wb_data_reg[merge_idx][b*8 +: 8] <= wr_data_i[b*8 +: 8];
		end else if (push) begin
			wb_addr_reg[tail_reg] <= wr_addr_i;
			wb_data_reg[tail_reg] <= wr_data_i;
			wb_type_reg[tail_reg] <= wr_type_i;
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			head_reg  <= 2'h0;
			tail_reg  <= 2'h0;
			count_reg <= 3'h0;
		end else begin
			if (push)
				tail_reg <= tail_reg + 2'h1;
			if (pop)
				head_reg <= head_reg + 2'h1;
			count_reg <= count_reg + {2'h0, push} - {2'h0, pop};
		end
	end

	// outgoing parity generated, checked on bus
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			bus.mem_addr_o          <= 32'h0;
			bus.mem_addr_oe         <= 1'b0;
			bus.mem_data_o          <= 32'h0;
			bus.mem_data_oe         <= 1'b0;
			bus.mem_parity_o        <= 4'h0;
			bus.access_type         <= 3'h0;
			bus.write_buffer_full_n <= 1'b1;
			bus.write_pending_n     <= 1'b1;
			bus.address_a           <= 1'b0;
			bus.parity_error        <= 1'b0;
		end else begin
			// write outputs gated by enable
			// Drop for one clock on retire so the old head is never offered twice
			bus.mem_data_oe <= !bus.write_buffer_out_en_n && count_reg != 3'h0 && !pop;
			bus.mem_data_o  <= wb_data_reg[head_reg];
			bus.mem_parity_o <= byte_par(wb_data_reg[head_reg]);
			// read address gated by its enable
			bus.mem_addr_oe <= (!bus.write_buffer_out_en_n && count_reg != 3'h0)
			                   || !bus.read_addr_out_en_n;
			bus.mem_addr_o  <= !bus.write_buffer_out_en_n ? wb_addr_reg[head_reg] : rd_addr_reg;
			bus.access_type <= !bus.write_buffer_out_en_n ? wb_type_reg[head_reg] : 3'h0;
			bus.write_buffer_full_n <= (count_reg + {2'h0, push} - {2'h0, pop}) != 3'h4;
			bus.write_pending_n <= (count_reg + {2'h0, push} - {2'h0, pop}) == 3'h0;
			bus.address_a <= |hit;
			bus.parity_error <= bus.mem_data_oe && byte_par(bus.mem_data_o) != bus.mem_parity_o;
		end
	end

	// hold read address unless latch enabled
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i)
			rd_addr_reg <= 32'h0;
		else if (bus.read_addr_latch_en)
			rd_addr_reg <= miss_addr_i;
	end

	// capture data only when clock enabled
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rd_data_reg <= 32'h0;
			rd_par_reg  <= 4'h0;
		end else if (!bus.read_data_clk_en_n) begin
			rd_data_reg <= bus.mem_data_in;
			rd_par_reg  <= bus.mem_parity_valid ? bus.mem_parity_in : byte_par(bus.mem_data_in);
		end
	end

	// read sequencer: request, stall, take words
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rd_state_reg       <= mem_if_pkg::RD_IDLE;
			bus.mem_read_req_n <= 1'b1;
			bus.read_status_n  <= 1'b1;
			stall_o            <= 1'b0;
			block_reg          <= 1'b0;
			beat_reg           <= 3'h0;
			refill_valid_o     <= 1'b0;
			refill_data_o      <= 32'h0;
			refill_index_o     <= 3'h0;
		end else begin
			refill_valid_o <= 1'b0;
			case (rd_state_reg)
				mem_if_pkg::RD_IDLE: begin
					if (miss_i) begin
						bus.mem_read_req_n <= 1'b0;
						bus.read_status_n  <= 1'b0;
						stall_o            <= 1'b1;
						rd_state_reg       <= mem_if_pkg::RD_WAIT;
					end
				end
				mem_if_pkg::RD_WAIT: begin
					if (bus.read_busy_ack) begin
						block_reg    <= miss_icache_i || bus.refill_size_select_pin;
						beat_reg     <= 3'h0;
						rd_state_reg <= mem_if_pkg::RD_BURST;
					end
				end
				mem_if_pkg::RD_BURST: begin
					if (!bus.read_data_clk_en_n) begin
						refill_valid_o <= 1'b1;
						refill_data_o  <= bus.mem_data_in;
						refill_index_o <= beat_reg;
						beat_reg       <= beat_reg + 3'h1;
						if (beat_reg == 3'h7 || !block_reg) begin
							bus.mem_read_req_n <= 1'b1;
							bus.read_status_n  <= 1'b1;
							stall_o            <= 1'b0;
							rd_state_reg       <= mem_if_pkg::RD_IDLE;
						end
					end
				end
				default: rd_state_reg <= mem_if_pkg::RD_IDLE;
			endcase
		end
	end

	// cold hold, then vectors; warm skips hold
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rst_state_reg       <= mem_if_pkg::RST_HOLD;
			rst_cnt_reg         <= 32'h0;
			cpu_reset_n_o       <= 1'b0;
			cpu_reset_out_n_o   <= 1'b0;
			init_vector_valid_o <= 1'b0;
			init_vector_o       <= 4'h0;
		end else if (!cold_reset_n_i) begin
			rst_state_reg       <= mem_if_pkg::RST_HOLD;
			rst_cnt_reg         <= 32'h0;
			cpu_reset_n_o       <= 1'b0;
			cpu_reset_out_n_o   <= 1'b0;
			init_vector_valid_o <= 1'b0;
		end else if (!warm_reset_n_i) begin
			rst_state_reg       <= mem_if_pkg::RST_VECTOR;
			rst_cnt_reg         <= 32'h0;
			cpu_reset_n_o       <= 1'b0;
			cpu_reset_out_n_o   <= 1'b0;
			init_vector_valid_o <= 1'b0;
		end else begin
			case (rst_state_reg)
				mem_if_pkg::RST_HOLD: begin
					rst_cnt_reg <= rst_cnt_reg + 32'h1;
					if (rst_cnt_reg == COLD_CYCLES - `VECTOR_CYCLES - 1) begin
						rst_cnt_reg   <= 32'h0;
						rst_state_reg <= mem_if_pkg::RST_VECTOR;
					end
				end
				mem_if_pkg::RST_VECTOR: begin
					init_vector_valid_o <= 1'b1;
					init_vector_o       <= 4'h1 << `BIG_ENDIAN_BIT;
					rst_cnt_reg         <= rst_cnt_reg + 32'h1;
					if (rst_cnt_reg == `VECTOR_CYCLES - 1)
						rst_state_reg <= mem_if_pkg::RST_RUN;
				end
				mem_if_pkg::RST_RUN: begin
					// release processor and buffered copy together
					init_vector_valid_o <= 1'b0;
					cpu_reset_n_o       <= 1'b1;
					cpu_reset_out_n_o   <= 1'b1;
					rst_state_reg       <= mem_if_pkg::RST_IDLE;
				end
				mem_if_pkg::RST_IDLE: begin
					cpu_reset_n_o     <= 1'b1;
					cpu_reset_out_n_o <= 1'b1;
				end
				default: rst_state_reg <= mem_if_pkg::RST_HOLD;
			endcase
		end
	end

	// user irqs two-stage sync, FPU one flop; FPU owns bit 2
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			irq_meta_reg <= 5'h1F;
			irq_sync_reg <= 5'h1F;
			cpu_irq_n_o  <= 6'h3F;
		end else begin
			irq_meta_reg <= user_irq_n_i;
			irq_sync_reg <= irq_meta_reg;
			cpu_irq_n_o  <= {irq_sync_reg[4:2], float_unit_irq_n_i, irq_sync_reg[1:0]};
		end
	end
endmodule

/* verilog/mem_if_regs.svh */
// Timing counts and field constants for the module memory interface
`ifndef MEM_IF_REGS_SVH
`define MEM_IF_REGS_SVH
`define CLK_PERIOD_NS     5
`define COLD_RESET_MS     15
`define COLD_RESET_CYCLES ((`COLD_RESET_MS * 1000000) / `CLK_PERIOD_NS)
`define VECTOR_CYCLES     4
`define WB_DEPTH          4
`define BLOCK_WORDS       8
`define WORD_IDX_LSB      2
`define WORD_IDX_MSB      4
`define BIG_ENDIAN_BIT    0
`define IRQ_FPU_BIT       2
`endif

/* verilog/mem_if_pkg.sv */
// Types used by the device end of the module memory interface
package mem_if_pkg;
	typedef logic [31:0] word_t;
	typedef logic [3:0]  par_t;
	typedef logic [2:0]  acc_t;
	typedef enum logic [3:0] {
		RST_HOLD   = 4'h1,
		RST_VECTOR = 4'h2,
		RST_RUN    = 4'h4,
		RST_IDLE   = 4'h8
	} rst_state_e;
	typedef enum logic [2:0] {
		RD_IDLE  = 3'h1,
		RD_WAIT  = 3'h2,
		RD_BURST = 3'h4
	} rd_state_e;
endpackage

/* verilog/mem_bus_if.sv */
// Pins between the module and the memory controller
`timescale 1ns/10ps
interface mem_bus_if;
	logic [31:0] mem_addr_o;
	logic        mem_addr_oe;
	logic [31:0] mem_addr_in;
	logic [31:0] mem_data_o;
	logic        mem_data_oe;
	logic [31:0] mem_data_in;
	logic [3:0]  mem_parity_o;
	logic [3:0]  mem_parity_in;
	logic        mem_parity_valid;
	logic [2:0]  access_type;
	logic        write_buffer_full_n;
	logic        write_pending_n;
	logic        write_done_ack;
	logic        write_buffer_out_en_n;
	logic        read_addr_out_en_n;
	logic        read_addr_latch_en;
	logic        read_data_clk_en_n;
	logic        read_status_n;
	logic        mem_read_req_n;
	logic        read_busy_ack;
	logic        address_a;
	logic        dcache_addr_latch_oe_n;
	logic        refill_size_select_pin;
	logic        parity_error;
	modport dev (
		output mem_addr_o, mem_addr_oe, mem_data_o, mem_data_oe, mem_parity_o, access_type,
		output write_buffer_full_n, write_pending_n, read_status_n, mem_read_req_n,
		output address_a, parity_error,
		input  mem_addr_in, mem_data_in, mem_parity_in, mem_parity_valid, write_done_ack,
		input  write_buffer_out_en_n, read_addr_out_en_n, read_addr_latch_en,
		input  read_data_clk_en_n, read_busy_ack, dcache_addr_latch_oe_n,
		input  refill_size_select_pin
	);
	modport ctl (
		input  mem_addr_o, mem_addr_oe, mem_data_o, mem_data_oe, mem_parity_o, access_type,
		input  write_buffer_full_n, write_pending_n, read_status_n, mem_read_req_n,
		input  address_a, parity_error,
		output mem_addr_in, mem_data_in, mem_parity_in, mem_parity_valid, write_done_ack,
		output write_buffer_out_en_n, read_addr_out_en_n, read_addr_latch_en,
		output read_data_clk_en_n, read_busy_ack, dcache_addr_latch_oe_n,
		output refill_size_select_pin
	);
endinterface

/* verilog/mem_ctl_end.sv */
// Memory controller end: retires writes and serves reads
`timescale 1ns/10ps
`include "mem_if_regs.svh"
module mem_ctl_end (
	input  wire logic clk_i,
	input  wire logic nrst_i,
	mem_bus_if.ctl    bus,
	input  wire logic block_refill_i,
	input  wire logic snoop_i,
	input  wire logic [31:0] snoop_addr_i,
	output logic      [31:0] wr_addr_o,
	output logic      [31:0] wr_data_o,
	output logic             wr_valid_o
);
	logic [31:0] mem_word_reg;
	logic [2:0]  beat_reg;
	logic        bursting_reg;
	logic        wr_ack_reg;
	logic        rd_busy_reg;
	logic        word_valid_reg;

	// Write side: grant bus, take one entry, acknowledge once
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			wr_ack_reg <= 1'b0;
			wr_valid_o <= 1'b0;
			wr_addr_o  <= 32'h0;
			wr_data_o  <= 32'h0;
		end else begin
			wr_ack_reg <= 1'b0;
			wr_valid_o <= 1'b0;
			if (!bus.write_pending_n && bus.mem_data_oe && !wr_ack_reg) begin
				wr_ack_reg <= 1'b1;
				wr_valid_o <= 1'b1;
				wr_addr_o  <= bus.mem_addr_o;
				wr_data_o  <= bus.mem_data_o;
			end
		end
	end

	// up to eight words on consecutive clocks after ack
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rd_busy_reg    <= 1'b0;
			bursting_reg   <= 1'b0;
			word_valid_reg <= 1'b0;
			beat_reg       <= 3'h0;
			mem_word_reg   <= 32'h0;
		end else begin
			rd_busy_reg    <= 1'b0;
			// Strobe follows bursting_reg one clock late, in step with the word register, so each word is stable when taken
			word_valid_reg <= bursting_reg;
			if (!bus.mem_read_req_n && !bursting_reg && !rd_busy_reg && !word_valid_reg) begin
				rd_busy_reg  <= 1'b1;
				bursting_reg <= 1'b1;
				beat_reg     <= 3'h0;
			end else if (bursting_reg) begin
				mem_word_reg <= {bus.mem_addr_o[31:5], beat_reg, 2'h0};
				beat_reg     <= beat_reg + 3'h1;
				// Device raises its request after the last word it wants
				if (beat_reg == 3'h7 || bus.mem_read_req_n)
					bursting_reg <= 1'b0;
			end
		end
	end

	always_comb begin
		// write buffer gated by our enable
		bus.write_buffer_out_en_n = bus.write_pending_n;
		// read address out only during reads
		bus.read_addr_out_en_n    = bus.mem_read_req_n;
		bus.read_addr_latch_en    = !bus.mem_read_req_n && !bursting_reg;
		bus.read_data_clk_en_n    = !word_valid_reg;
		bus.write_done_ack        = wr_ack_reg;
		bus.read_busy_ack         = rd_busy_reg;
		bus.dcache_addr_latch_oe_n = snoop_i;
		bus.refill_size_select_pin = block_refill_i;
		bus.mem_addr_in      = snoop_addr_i;
		bus.mem_data_in      = mem_word_reg;
		bus.mem_parity_in    = 4'h0;
		bus.mem_parity_valid = 1'b0;
	end
endmodule

/* verif/mem_if_chk.sv */
// Concurrent checks on the pins between the two ends
`timescale 1ns/10ps
module mem_if_chk (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic write_buffer_full_n,
	input wire logic write_pending_n,
	input wire logic write_done_ack,
	input wire logic write_buffer_out_en_n,
	input wire logic read_addr_out_en_n,
	input wire logic mem_addr_oe,
	input wire logic mem_data_oe,
	input wire logic read_status_n,
	input wire logic mem_read_req_n,
	input wire logic read_busy_ack,
	input wire logic read_data_clk_en_n,
	input wire logic refill_size_select_pin,
	input wire logic address_a
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!nrst_i);
	property p_full_pending;
		!write_buffer_full_n |-> !write_pending_n;
	endproperty
	a_full_pending: assert property (p_full_pending) else $error("full without pending");
	property p_full_cause;
		!write_buffer_full_n |-> $past(!write_pending_n);
	endproperty
	a_full_cause: assert property (p_full_cause) else $error("full too early");
	property p_data_oe;
		mem_data_oe |-> $past(!write_buffer_out_en_n);
	endproperty
	a_data_oe: assert property (p_data_oe) else $error("data driven unasked");
	property p_addr_oe;
		mem_addr_oe |-> $past(!write_buffer_out_en_n || !read_addr_out_en_n);
	endproperty
	a_addr_oe: assert property (p_addr_oe) else $error("address driven unasked");
	property p_rd_status;
		!mem_read_req_n |-> !read_status_n;
	endproperty
	a_rd_status: assert property (p_rd_status) else $error("status high in read");
	property p_busy;
		$fell(mem_read_req_n) |-> ##[0:4] read_busy_ack;
	endproperty
	a_busy: assert property (p_busy) else $error("read not acknowledged");
	property p_retire;
		$fell(write_pending_n) |-> ##[1:8] write_done_ack;
	endproperty
	a_retire: assert property (p_retire) else $error("write never retired");
	property p_burst;
		read_busy_ack && refill_size_select_pin |-> ##[1:3] (!read_data_clk_en_n) [*8];
	endproperty
	a_burst: assert property (p_burst) else $error("burst not eight clocks");
	property p_address_a;
		address_a |-> $past(!write_pending_n);
	endproperty
	a_address_a: assert property (p_address_a) else $error("address_a with empty buffer");
	c_full: cover property (!write_buffer_full_n);
	c_ack: cover property (write_done_ack);
	c_burst: cover property (read_busy_ack && refill_size_select_pin);
endmodule

/* verif/cpu_module_memory_interface_tb_top.sv */
// Bench joining both ends, with a queue model of the write buffer
`timescale 1ns/10ps
`define CHK(n, e, g) begin num_checks++; if ((e) !== (g)) begin miscompares++; $display("mismatch %s expected %h seen %h", n, e, g); end end
module cpu_module_memory_interface_tb_top;
	localparam int COLD = 200;
	logic        clk_i, nrst_i, cold_n, warm_n, fpu_n, wr_valid, miss, micache, block, snoop;
	logic [4:0]  uirq_n;
	logic [31:0] wr_addr, wr_data, miss_addr, lfsr_state, rf_data, cw_addr, cw_data, iv_all;
	logic [3:0]  wr_be, iv;
	logic [2:0]  rf_idx;
	logic [5:0]  irq_n;
	logic        wr_ready, stall, rf_valid, crst_n, crst_out_n, iv_valid, cw_valid;
	logic        full_seen, conf_seen, req_seen, iv_seen;
	logic [31:0] exp_a[$], exp_d[$], exp_m[$];
	int          miscompares, num_checks, rf_cnt, rf_exp, cyc, i, n;
	mem_bus_if mem_bus_if_i ();
	mem_dev_end #(.COLD_CYCLES(COLD)) mem_dev_end_i (.clk_i(clk_i), .nrst_i(nrst_i),
		.bus(mem_bus_if_i.dev), .cold_reset_n_i(cold_n), .warm_reset_n_i(warm_n),
		.user_irq_n_i(uirq_n), .float_unit_irq_n_i(fpu_n), .wr_valid_i(wr_valid),
		.wr_addr_i(wr_addr), .wr_data_i(wr_data), .wr_be_i(wr_be), .wr_type_i(3'h0),
		.miss_i(miss), .miss_icache_i(micache), .miss_addr_i(miss_addr),
		.wr_ready_o(wr_ready), .stall_o(stall), .refill_valid_o(rf_valid),
		.refill_data_o(rf_data), .refill_index_o(rf_idx), .cpu_irq_n_o(irq_n),
		.cpu_reset_n_o(crst_n), .cpu_reset_out_n_o(crst_out_n),
		.init_vector_valid_o(iv_valid), .init_vector_o(iv));
	mem_ctl_end mem_ctl_end_i (.clk_i(clk_i), .nrst_i(nrst_i), .bus(mem_bus_if_i.ctl),
		.block_refill_i(block), .snoop_i(snoop), .snoop_addr_i(lfsr_state),
		.wr_addr_o(cw_addr), .wr_data_o(cw_data), .wr_valid_o(cw_valid));
	mem_if_chk mem_if_chk_i (.clk_i(clk_i), .nrst_i(nrst_i),
		.write_buffer_full_n(mem_bus_if_i.write_buffer_full_n),
		.write_pending_n(mem_bus_if_i.write_pending_n),
		.write_done_ack(mem_bus_if_i.write_done_ack),
		.write_buffer_out_en_n(mem_bus_if_i.write_buffer_out_en_n),
		.read_addr_out_en_n(mem_bus_if_i.read_addr_out_en_n),
		.mem_addr_oe(mem_bus_if_i.mem_addr_oe), .mem_data_oe(mem_bus_if_i.mem_data_oe),
		.read_status_n(mem_bus_if_i.read_status_n),
		.mem_read_req_n(mem_bus_if_i.mem_read_req_n),
		.read_busy_ack(mem_bus_if_i.read_busy_ack),
		.read_data_clk_en_n(mem_bus_if_i.read_data_clk_en_n),
		.refill_size_select_pin(mem_bus_if_i.refill_size_select_pin),
		.address_a(mem_bus_if_i.address_a));
	function logic [31:0] lfsr();
		lfsr_state = {lfsr_state[30:0], ^(lfsr_state & 32'h80200003)};
		return lfsr_state;
	endfunction
	task end_of_test();
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task wait_run();
		for (n = 0; n < 2000 && crst_n !== 1'b1; n++) @(negedge clk_i);
	endtask
	task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] be);
		int k, j;
		logic [31:0] m;
		m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
		@(negedge clk_i);
		wr_valid = 1'b1;
		wr_addr = a;
		wr_data = d;
		wr_be = be;
		#1;
		for (j = 0; j < 50 && wr_ready !== 1'b1; j++) @(negedge clk_i) #1;
		@(posedge clk_i);
		k = 0;
		for (j = 1; j < exp_a.size(); j++) if (exp_a[j] == a) k = j;
		if (k == 0) begin
			exp_a.push_back(a);
			exp_d.push_back(d);
			exp_m.push_back(m);
		end else begin
			exp_d[k] = (exp_d[k] & ~m) | (d & m);
			exp_m[k] = exp_m[k] | m;
		end
	endtask
	task automatic rd(input logic ic, input logic bl);
		int j;
		@(negedge clk_i);
		block = bl;
		micache = ic;
		miss_addr = lfsr() & 32'hFFFFFFE0;
		rf_cnt = 0;
		rf_exp = (ic | bl) ? 8 : 1;
		miss = 1'b1;
		for (j = 0; j < 20 && stall !== 1'b1; j++) @(negedge clk_i);
		miss = 1'b0;
		for (j = 0; j < 60 && stall !== 1'b0; j++) @(negedge clk_i);
		repeat (2) @(negedge clk_i);
		`CHK("refill_words", rf_exp, rf_cnt)
		`CHK("stall_end", 1'b0, stall)
	endtask
	always @(negedge clk_i) begin
		if (nrst_i === 1'b1) begin
			`CHK("reset_copy", crst_n, crst_out_n)
			`CHK("parity", 1'b0, mem_bus_if_i.parity_error)
			if (mem_bus_if_i.write_buffer_full_n === 1'b0) full_seen = 1'b1;
			if (mem_bus_if_i.address_a === 1'b1) conf_seen = 1'b1;
			if (mem_bus_if_i.mem_read_req_n === 1'b0) req_seen = 1'b1;
			if (iv_valid === 1'b1) iv_seen = 1'b1;
			if (iv_valid === 1'b1) iv_all = iv_all | iv;
			if (rf_valid === 1'b1) begin
				if (rf_exp == 8) `CHK("refill_index", rf_cnt[2:0], rf_idx)
				`CHK("refill_word", {rf_cnt[2:0], 2'h0}, rf_data[4:0])
				rf_cnt++;
			end
			if (cw_valid === 1'b1) begin
				`CHK("wr_queue", 1'b1, exp_a.size() != 0)
				if (exp_a.size() != 0) begin
					`CHK("wr_addr", exp_a[0], cw_addr)
					`CHK("wr_data", exp_d[0] & exp_m[0], cw_data & exp_m[0])
					void'(exp_a.pop_front());
					void'(exp_d.pop_front());
					void'(exp_m.pop_front());
				end
			end
		end
	end
	always @(posedge clk_i) begin
		cyc++;
		// Run needs about 520 cycles
		if (cyc == 8000) begin
			miscompares++;
			end_of_test();
		end
	end
	initial begin
		clk_i = 0;
		forever #2.5 clk_i = ~clk_i;
	end
	initial begin
		{nrst_i, wr_valid, miss, micache, block, snoop, full_seen, conf_seen} = '0;
		{req_seen, iv_seen, iv_all, wr_addr, wr_data, wr_be, miss_addr} = '0;
		{cold_n, warm_n, fpu_n, uirq_n} = '1;
		lfsr_state = 32'hF366;
		{miscompares, num_checks, rf_cnt, rf_exp, cyc} = '0;
		repeat (2) @(negedge clk_i);
		`CHK("reset_low", 1'b0, crst_n)
		`CHK("irq_idle", 6'h3F, irq_n)
		repeat (2) @(negedge clk_i);
		nrst_i = 1'b1;
		wait_run();
		`CHK("cold_len", 1'b1, n >= COLD - 8 && n <= COLD + 8)
		`CHK("big_endian", 1'b1, iv_all[0])
		for (i = 0; i < 2; i++) begin
			@(negedge clk_i);
			{warm_n, cold_n} = i ? 2'b10 : 2'b01;
			iv_seen = 1'b0;
			@(negedge clk_i);
			{warm_n, cold_n} = 2'b11;
			repeat (2) @(negedge clk_i);
			wait_run();
			`CHK("vectors", 1'b1, iv_seen)
			`CHK("hold_len", i == 1, n >= COLD - 12)
		end
		$display("test reset done");
		for (i = 0; i < 4; i++) begin
			void'(lfsr());
			{fpu_n, uirq_n} = lfsr_state[5:0];
			repeat (4) @(negedge clk_i);
			`CHK("irq", {uirq_n[4:2], fpu_n, uirq_n[1:0]}, irq_n)
		end
		$display("test interrupts done");
		for (i = 0; i < 2; i++) wr(32'h100 + i * 4, lfsr(), 4'hF);
		wr(32'h200, 32'h11, 4'h1);
		wr(32'h200, 32'h2200, 4'h2);
		for (i = 0; i < 6; i++) wr(32'h300 + i * 4, lfsr(), 4'hF);
		@(negedge clk_i);
		wr_valid = 1'b0;
		for (i = 0; i < 100 && mem_bus_if_i.write_pending_n !== 1'b1; i++) @(negedge clk_i);
		repeat (4) @(negedge clk_i);
		`CHK("full_seen", 1'b1, full_seen)
		`CHK("address_a", 1'b1, conf_seen)
		`CHK("drained", 0, exp_a.size())
		`CHK("pending_idle", 1'b1, mem_bus_if_i.write_pending_n)
		$display("test writes done");
		for (i = 0; i < 4; i++) rd(i[0], i[1]);
		`CHK("read_req", 1'b1, req_seen)
		// latch enable raised only for snoop
		snoop = 1'b1;
		repeat (2) @(negedge clk_i);
		`CHK("snoop_oe", 1'b1, mem_bus_if_i.dcache_addr_latch_oe_n)
		snoop = 1'b0;
		@(negedge clk_i);
		`CHK("snoop_idle", 1'b0, mem_bus_if_i.dcache_addr_latch_oe_n)
		$display("test reads done");
		end_of_test();
	end
endmodule
